// *** srac_defines.svh ***
`ifndef SRAC_DEFINES_SVH
`define SRAC_DEFINES_SVH

// Clock and re-arm timing
`define SRAC_CLK_PERIOD_NS 100
`define SRAC_REARM_PERIODS 2
`define SRAC_REARM_CYC (`SRAC_REARM_PERIODS)

// Level indices
`define SRAC_LVL_RX 0
`define SRAC_LVL_TX 1
`define SRAC_LVL_MODEM 2
`define SRAC_NO_LEVEL 2'h3

// Vector layout and request type codes
`define SRAC_VEC_USER_LSB 3
`define SRAC_VEC_MODEM 3'h1
`define SRAC_VEC_TX 3'h2
`define SRAC_VEC_RX_CLEAN 3'h3
`define SRAC_VEC_RX_EXC 3'h7

// Receive queue depth
`define SRAC_RX_DEPTH 8

// Pin bundle reset: request lines idle high, address zero, ack idle high
`define SRAC_PIN_RESET 12'hE01

`endif

// *** srac_pkg.sv ***
package srac_pkg;

    // Acknowledge machine states
    typedef enum logic [1:0] {
        SRAC_IDLE = 2'b00,
        SRAC_REQ_ACTIVE = 2'b01,
        SRAC_PASS_ACK = 2'b10,
        SRAC_KEEP_ACK = 2'b11
    } srac_ack_state_e;

    // Index of a request level
    typedef logic [1:0] srac_level_t;

endpackage

// *** srac_level_if.sv ***
interface srac_level_if;
    logic ack;
    logic match;
    logic int_req;
    logic req;
    logic grant;
    logic pass;

    // Acknowledge machine side
    modport fsm (
        input ack,
        input match,
        input int_req,
        output req,
        output grant,
        output pass
    );

    // Controller side
    modport ctrl (
        output ack,
        output match,
        output int_req,
        input req,
        input grant,
        input pass
    );
endinterface

// *** srac_level_fsm.sv ***
module srac_level_fsm (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level signals
    srac_level_if.fsm lvl
);

    srac_pkg::srac_ack_state_e state;
    srac_pkg::srac_ack_state_e next_state;

    // Next state; ack without match is never passed on
    always_comb begin
        next_state = state;
        unique case (state)
            srac_pkg::SRAC_IDLE: begin
                if (lvl.int_req) begin
                    next_state = srac_pkg::SRAC_REQ_ACTIVE;
                end else if (lvl.ack && lvl.match) begin
                    next_state = srac_pkg::SRAC_PASS_ACK;
                end
            end
            srac_pkg::SRAC_REQ_ACTIVE: begin
                // No wait for other levels' compare, keeps response fast
                if (lvl.ack && lvl.match) begin
                    next_state = srac_pkg::SRAC_KEEP_ACK;
                end
            end
            srac_pkg::SRAC_PASS_ACK: begin
                if (!lvl.ack) begin
                    next_state = srac_pkg::SRAC_IDLE;
                end
            end
            srac_pkg::SRAC_KEEP_ACK: begin
                if (!lvl.ack) begin
                    next_state = srac_pkg::SRAC_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= srac_pkg::SRAC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Output decode; idle drives nothing
    assign lvl.req = (state == srac_pkg::SRAC_REQ_ACTIVE);
    assign lvl.pass = (state == srac_pkg::SRAC_PASS_ACK);
    assign lvl.grant = (state == srac_pkg::SRAC_KEEP_ACK);

endmodule

// *** srac_top.sv ***
// What this block does
// - One acknowledge machine per request level
// - Software ack read forces level match
// - Merge three pass outputs into chain output
// - Idle: request first, else match passes
// - Request active: only matching ack is kept
// - Pass or keep until ack input drops
// - No chain glitch, no waiting on others
// - Watch own and external request values
// - Differ at ack end: withhold until idle
// - Three levels: receive, transmit, modem
// - Receive vector: clean data or exception
// - Receive requests kept in arrival order
// - Errors, specials, breaks, timeouts are exceptions
// - Clean request: threshold, timer or exception
// - Clean grant returns clean data vector
// - Count clean bytes arriving during service
// - Condition still true re-raises request
// - Address compared against three match values
// - Kept ack drives vector onto data
// - End of service pops, rearm later
`include "srac_defines.svh"

module srac_top #(
    parameter int RX_DEPTH = `SRAC_RX_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Acknowledge daisy chain and address pins
    input wire logic chain_ack_in_n,
    input wire logic [7:0] ack_addr,
    output logic chain_ack_out_n,
    // Match values per level
    input wire logic [7:0] rx_match_value,
    input wire logic [7:0] tx_match_value,
    input wire logic [7:0] modem_match_value,
    // Software acknowledge reads, one per level
    input wire logic [2:0] sw_ack_rd,
    // Shared open-drain request lines
    input wire logic rx_level_req_n_in,
    output logic rx_level_req_n_out,
    output logic rx_level_req_n_oe,
    input wire logic tx_level_req_n_in,
    output logic tx_level_req_n_out,
    output logic tx_level_req_n_oe,
    input wire logic modem_level_req_n_in,
    output logic modem_level_req_n_out,
    output logic modem_level_req_n_oe,
    // Internal requests of transmit and modem levels
    input wire logic tx_int_req,
    input wire logic modem_int_req,
    // Receive character events
    input wire logic rx_byte_stb,
    input wire logic rx_byte_err,
    input wire logic rx_byte_special,
    input wire logic rx_byte_break,
    input wire logic rx_nndt_stb,
    input wire logic rx_timer_expired,
    input wire logic [3:0] rx_threshold,
    input wire logic rx_host_read_stb,
    // End of service write and vector user bits
    input wire logic end_of_service_stb,
    input wire logic [4:0] global_vector_reg,
    // Acknowledge data bus
    output logic [7:0] ack_data,
    output logic ack_data_oe,
    // Status towards the rest of the chip
    output logic [2:0] level_grant,
    output logic [2:0] in_service,
    output logic [3:0] rx_clean_count,
    output logic rx_exc_pending,
    output logic rx_overrun
);

    localparam int NLVL = 3;
    localparam int CW = 4;

    // Address compare, used once per level
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] m);
        return a == m;
    endfunction

    // Pin synchronisers: a change counts when stages two and three agree
    logic [11:0] pin_raw;
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic [11:0] pin_s3;
    logic [11:0] pin_f;
    logic [11:0] pin_agree;

    assign pin_raw = {modem_level_req_n_in, tx_level_req_n_in, rx_level_req_n_in,
                      ack_addr, chain_ack_in_n};
    assign pin_agree = ~(pin_s2 ^ pin_s3);

    // Three stages plus agreement filter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1 <= `SRAC_PIN_RESET;
            pin_s2 <= `SRAC_PIN_RESET;
            pin_s3 <= `SRAC_PIN_RESET;
            pin_f <= `SRAC_PIN_RESET;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (pin_f & ~pin_agree) | (pin_s3 & pin_agree);
        end
    end

    // Filtered pin views
    logic ack_act;
    logic ack_prev;
    logic ack_end;
    logic [7:0] addr_f;
    logic [2:0] ext_act;

    assign ack_act = ~pin_f[0];
    assign addr_f = pin_f[8:1];
    assign ext_act = ~pin_f[11:9];
    assign ack_end = ack_prev & ~ack_act;

    // Ack history for end-of-cycle detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_prev <= 1'b0;
        end else begin
            ack_prev <= ack_act;
        end
    end

    // Receive level bookkeeping
    logic [CW-1:0] clean_cnt;
    logic [CW-1:0] after_cnt;
    logic [CW-1:0] next_clean;
    logic [CW-1:0] next_after;
    logic exc_pend;
    logic timer_lat;
    logic rx_sub_exc;
    logic rx_exc_in;
    logic rx_clean_in;
    logic rx_full;
    logic rx_clean_req;
    logic rx_exc_req;
    logic rx_rd;
    logic rx_exc_done;
    logic rx_clean_ctx;

    // Classification of arriving characters
    assign rx_exc_in = (rx_byte_stb & (rx_byte_err | rx_byte_special | rx_byte_break))
                       | rx_nndt_stb;
    assign rx_clean_in = rx_byte_stb & ~rx_byte_err & ~rx_byte_special & ~rx_byte_break;
    assign rx_full = (CW'(clean_cnt + after_cnt) >= CW'(RX_DEPTH));

    // Clean request only with clean data and a trigger
    assign rx_clean_req = (clean_cnt != '0)
                          && ((clean_cnt >= rx_threshold) || timer_lat || exc_pend);
    assign rx_exc_req = (clean_cnt == '0) && exc_pend;

    // Service stack
    srac_pkg::srac_level_t stk [NLVL];
    logic [1:0] sp;
    logic [1:0] sp_pop;
    srac_pkg::srac_level_t svc_top;
    logic pop;
    logic push;
    srac_pkg::srac_level_t push_lvl;
    logic [2:0] grant_rise;
    logic [2:0] grant_q;
    logic [2:0] svc_flag;

    assign svc_top = (sp != 2'h0) ? stk[sp - 2'h1] : `SRAC_NO_LEVEL;
    assign pop = end_of_service_stb && (sp != 2'h0);
    assign sp_pop = pop ? (sp - 2'h1) : sp;
    assign push = |grant_rise;
    assign push_lvl = grant_rise[0] ? 2'h0 : (grant_rise[1] ? 2'h1 : 2'h2);
    assign rx_clean_ctx = (svc_top == 2'(`SRAC_LVL_RX)) && !rx_sub_exc;
    assign rx_rd = rx_clean_ctx && rx_host_read_stb && (clean_cnt != '0);
    assign rx_exc_done = pop && (svc_top == 2'(`SRAC_LVL_RX)) && rx_sub_exc;

    // Levels that sit anywhere on the stack
    always_comb begin
        svc_flag = 3'h0;
        for (int i = 0; i < NLVL; i++) begin
            if (2'(i) < sp) begin
                svc_flag[stk[i]] = 1'b1;
            end
        end
    end

    // Next receive counts; clean bytes behind an exception wait their turn
    always_comb begin
        next_clean = clean_cnt;
        next_after = after_cnt;
        if (rx_rd) begin
            next_clean = next_clean - CW'(1);
        end
        if (rx_exc_done) begin
            next_clean = CW'(next_clean + after_cnt);
            next_after = '0;
        end
        if (rx_clean_in && !rx_full) begin
            if (exc_pend && !rx_exc_done) begin
                next_after = next_after + CW'(1);
            end else begin
                next_clean = next_clean + CW'(1);
            end
        end
    end

    // Receive state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clean_cnt <= '0;
            after_cnt <= '0;
        end else begin
            clean_cnt <= next_clean;
            after_cnt <= next_after;
        end
    end

    // Exception slot; a new exception wins over the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exc_pend <= 1'b0;
        end else if (rx_exc_in) begin
            exc_pend <= 1'b1;
        end else if (rx_exc_done) begin
            exc_pend <= 1'b0;
        end
    end

    // Timer trigger; cleared when the clean request is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_lat <= 1'b0;
        end else if (rx_timer_expired && (clean_cnt != '0)) begin
            timer_lat <= 1'b1;
        end else if (grant_rise[`SRAC_LVL_RX] && rx_clean_req) begin
            timer_lat <= 1'b0;
        end
    end

    // Overrun flag; second exception or full queue
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_overrun <= 1'b0;
        end else begin
            rx_overrun <= (rx_exc_in && exc_pend && !rx_exc_done) || (rx_clean_in && rx_full);
        end
    end

    // Stack push and pop; pop handled first in a shared cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp <= 2'h0;
            grant_q <= 3'h0;
            rx_sub_exc <= 1'b0;
            for (int i = 0; i < NLVL; i++) begin
                stk[i] <= 2'h0;
            end
        end else begin
            grant_q <= level_grant;
            sp <= push ? (sp_pop + 2'h1) : sp_pop;
            if (push) begin
                stk[sp_pop] <= push_lvl;
            end
            if (grant_rise[`SRAC_LVL_RX]) begin
                rx_sub_exc <= !rx_clean_req;
            end
        end
    end

    // Level inputs gathered for the generate loop
    logic [7:0] match_val [NLVL];
    logic [2:0] raw_req;
    logic [2:0] hw_hit;
    logic [2:0] pass_v;
    logic [2:0] drive_v;

    assign match_val[0] = rx_match_value;
    assign match_val[1] = tx_match_value;
    assign match_val[2] = modem_match_value;
    assign raw_req = {modem_int_req, tx_int_req, rx_clean_req | rx_exc_req};
    assign grant_rise = level_grant & ~grant_q;

    // One acknowledge machine per level with fair share and rearm gating
    generate
        for (genvar l = 0; l < NLVL; l++) begin : g_lvl
            srac_level_if u_if ();
            logic fs_block;
            logic [1:0] rearm;

            assign hw_hit[l] = ack_act && addr_hit(addr_f, match_val[l]);
            assign u_if.ack = ack_act | sw_ack_rd[l];
            assign u_if.match = hw_hit[l] | sw_ack_rd[l];
            assign u_if.int_req = raw_req[l] && !svc_flag[l] && !fs_block
                                  && (rearm == 2'h0);
            assign level_grant[l] = u_if.grant;
            assign pass_v[l] = u_if.pass;
            assign drive_v[l] = u_if.req && !fs_block;

            srac_level_fsm u_fsm (
                .clk(clk),
                .rst_n(rst_n),
                .lvl(u_if.fsm)
            );

            // Others share the line: hold off until it goes idle
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    fs_block <= 1'b0;
                end else if (ack_end && (drive_v[l] != ext_act[l])) begin
                    fs_block <= 1'b1;
                end else if (!ext_act[l]) begin
                    fs_block <= 1'b0;
                end
            end

            // Re-request held off after this level is popped
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    rearm <= 2'h0;
                end else if (pop && (svc_top == 2'(l))) begin
                    rearm <= 2'(`SRAC_REARM_CYC);
                end else if (rearm != 2'h0) begin
                    rearm <= rearm - 2'h1;
                end
            end
        end
    endgenerate

    // Open-drain request pins only ever pull low
    assign rx_level_req_n_out = 1'b0;
    assign tx_level_req_n_out = 1'b0;
    assign modem_level_req_n_out = 1'b0;
    assign rx_level_req_n_oe = drive_v[`SRAC_LVL_RX];
    assign tx_level_req_n_oe = drive_v[`SRAC_LVL_TX];
    assign modem_level_req_n_oe = drive_v[`SRAC_LVL_MODEM];

    // Vector type for the level being granted
    logic [2:0] vec_code;
    assign vec_code = grant_rise[`SRAC_LVL_RX] ? (rx_clean_req ? `SRAC_VEC_RX_CLEAN : `SRAC_VEC_RX_EXC)
                      : (grant_rise[`SRAC_LVL_TX] ? `SRAC_VEC_TX : `SRAC_VEC_MODEM);

    // Chain output registered so no decode glitch reaches the chain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_ack_out_n <= 1'b1;
            ack_data <= 8'h00;
            ack_data_oe <= 1'b0;
        end else begin
            chain_ack_out_n <= ~|pass_v;
            ack_data_oe <= |level_grant;
            if (push) begin
                ack_data <= {global_vector_reg, vec_code};
            end
        end
    end

    // Status outputs
    assign in_service = svc_flag;
    assign rx_clean_count = clean_cnt;
    assign rx_exc_pending = exc_pend;

endmodule

// *** srac_asserts.sv ***
`include "srac_defines.svh"

module srac_asserts #(
    parameter int RX_DEPTH = `SRAC_RX_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Acknowledge chain
    input wire logic chain_ack_in_n,
    input wire logic chain_ack_out_n,
    input wire logic [2:0] sw_ack_rd,
    // Transmit level request
    input wire logic tx_level_req_n_oe,
    input wire logic tx_int_req,
    // Service and vector
    input wire logic end_of_service_stb,
    input wire logic [4:0] global_vector_reg,
    input wire logic [7:0] ack_data,
    input wire logic ack_data_oe,
    input wire logic [2:0] level_grant,
    input wire logic [2:0] in_service,
    input wire logic [3:0] rx_clean_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // A kept acknowledge never leaks down the chain
    keep_blocks_chain_a: assert property (|level_grant |-> chain_ack_out_n)
        else $error("chain ack out low during a grant");
    // Distinct match values give one grant at most
    grant_onehot_a: assert property ($onehot0(level_grant))
        else $error("more than one level granted");
    // Grant needs a hardware or software acknowledge
    grant_cause_a: assert property ($rose(level_grant[1]) |-> !$past(chain_ack_in_n, 2) || $past(sw_ack_rd[1]))
        else $error("transmit grant without acknowledge");
    // Chain output falls only after an acknowledge
    chain_cause_a: assert property ($fell(chain_ack_out_n) |->
        !$past(chain_ack_in_n, 2) || $past(|sw_ack_rd) || $past(|sw_ack_rd, 2))
        else $error("chain ack out fell without acknowledge");
    // Request pin released while kept
    keep_drops_req_a: assert property (level_grant[1] |-> !tx_level_req_n_oe)
        else $error("transmit request driven during grant");
    // Request pin only follows an internal request
    req_cause_a: assert property ($rose(tx_level_req_n_oe) |-> $past(tx_int_req))
        else $error("transmit request without internal request");
    // Software read grants for exactly one cycle
    sw_grant_once_a: assert property (sw_ack_rd[1] && tx_level_req_n_oe |=> level_grant[1] ##1 !level_grant[1])
        else $error("software acknowledge grant not one cycle");
    // Vector follows the grant by one edge
    vector_tx_a: assert property ($rose(level_grant[1]) |=>
        ack_data_oe && ack_data == {global_vector_reg, `SRAC_VEC_TX})
        else $error("transmit vector wrong after grant");
    // Popped level waits before asking again
    rearm_gap_a: assert property (end_of_service_stb && in_service == 3'h2 |=> !tx_level_req_n_oe [*2])
        else $error("transmit request re-armed too soon");
    // Count never exceeds the queue depth
    count_bound_a: assert property (rx_clean_count <= RX_DEPTH)
        else $error("clean count above depth");

    // Main scenarios
    keep_c: cover property ($rose(level_grant[1]));
    pass_c: cover property ($fell(chain_ack_out_n));
    rx_grant_c: cover property ($rose(level_grant[0]));
endmodule

bind srac_top srac_asserts #(.RX_DEPTH(RX_DEPTH)) u_chk (.clk(clk), .rst_n(rst_n),
    .chain_ack_in_n(chain_ack_in_n), .chain_ack_out_n(chain_ack_out_n), .sw_ack_rd(sw_ack_rd),
    .tx_level_req_n_oe(tx_level_req_n_oe), .tx_int_req(tx_int_req), .end_of_service_stb(end_of_service_stb),
    .global_vector_reg(global_vector_reg), .ack_data(ack_data), .ack_data_oe(ack_data_oe),
    .level_grant(level_grant), .in_service(in_service), .rx_clean_count(rx_clean_count));

// *** srac_host_model.sv ***
module srac_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench control
    input wire logic start,
    input wire logic [7:0] addr,
    input wire logic [2:0] peer_pull,
    output logic done,
    // Device pins
    input wire logic [2:0] oe,
    output logic [2:0] req_n_in,
    output logic chain_ack_in_n,
    output logic [7:0] ack_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;

    // Shared lines pulled up, low if anyone drives
    assign req_n_in = ~(oe | peer_pull);

    // Ack held ten cycles, address inverted once released
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!rst_n) begin
            cnt <= 5'h00;
            chain_ack_in_n <= 1'b1;
            ack_addr <= 8'h00;
        end else if (start && cnt == 5'h00) begin
            cnt <= 5'h01;
            ack_addr <= addr;
            chain_ack_in_n <= 1'b0;
        end else if (cnt != 5'h00) begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h0A) begin
                chain_ack_in_n <= 1'b1;
                ack_addr <= ~ack_addr;
            end
            if (cnt == 5'h14) begin
                cnt <= 5'h00;
                done <= 1'b1;
            end
        end
    end
endmodule

// *** srac_top_tb_top.sv ***
`include "srac_defines.svh"

module srac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] sel;
        logic txr;
        logic mdr;
        logic [2:0] grant;
        logic pass;
        logic [2:0] vtype;
    } srac_row_s;
    localparam logic [4:0] GVR = 5'h15;
    logic clk = 0, rst_n = 0, ack_n, done, start = 0, hold_req = 0;
    logic [7:0] ack_addr, host_addr = 8'h00, ack_data, seen_vec;
    logic [2:0] sw_ack_rd = 0, peer_pull = 0, req_n, level_grant, in_service, seen_grant;
    logic rx_oe, tx_oe, md_oe, chain_out_n, ack_data_oe, seen_pass, eos_stb = 0, rd_stb = 0, timer = 0;
    logic tx_int_req = 0, modem_int_req = 0, stb = 0, err = 0, spec = 0, brk = 0, nndt = 0;
    logic [3:0] rx_clean_count;
    logic [2:0] req_out;
    logic rx_exc_pending, rx_overrun;
    logic [7:0] match_tab [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    int failures = 0, num_checks = 0;
    srac_row_s rows [7] = '{
        '{2'd1, 1'b1, 1'b0, 3'h2, 1'b0, `SRAC_VEC_TX}, '{2'd2, 1'b0, 1'b1, 3'h4, 1'b0, `SRAC_VEC_MODEM},
        '{2'd1, 1'b0, 1'b0, 3'h0, 1'b1, 3'h0}, '{2'd0, 1'b0, 1'b0, 3'h0, 1'b1, 3'h0},
        '{2'd3, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0}, '{2'd2, 1'b1, 1'b0, 3'h0, 1'b1, 3'h0},
        '{2'd1, 1'b1, 1'b0, 3'h2, 1'b0, `SRAC_VEC_TX}};

    always #50 clk = ~clk;

    srac_top dut (.clk(clk), .rst_n(rst_n), .chain_ack_in_n(ack_n), .ack_addr(ack_addr),
        .chain_ack_out_n(chain_out_n), .rx_match_value(match_tab[0]), .tx_match_value(match_tab[1]),
        .modem_match_value(match_tab[2]), .sw_ack_rd(sw_ack_rd), .rx_level_req_n_in(req_n[0]),
        .rx_level_req_n_out(req_out[0]), .rx_level_req_n_oe(rx_oe), .tx_level_req_n_in(req_n[1]),
        .tx_level_req_n_out(req_out[1]), .tx_level_req_n_oe(tx_oe), .modem_level_req_n_in(req_n[2]),
        .modem_level_req_n_out(req_out[2]), .modem_level_req_n_oe(md_oe), .tx_int_req(tx_int_req),
        .modem_int_req(modem_int_req), .rx_byte_stb(stb), .rx_byte_err(err), .rx_byte_special(spec),
        .rx_byte_break(brk), .rx_nndt_stb(nndt), .rx_timer_expired(timer), .rx_threshold(4'h3),
        .rx_host_read_stb(rd_stb), .end_of_service_stb(eos_stb), .global_vector_reg(GVR),
        .ack_data(ack_data), .ack_data_oe(ack_data_oe), .level_grant(level_grant), .in_service(in_service),
        .rx_clean_count(rx_clean_count), .rx_exc_pending(rx_exc_pending), .rx_overrun(rx_overrun));

    srac_host_model host (.clk(clk), .rst_n(rst_n), .start(start), .addr(host_addr), .peer_pull(peer_pull),
        .done(done), .oe({md_oe, tx_oe, rx_oe}), .req_n_in(req_n), .chain_ack_in_n(ack_n), .ack_addr(ack_addr));

    // Collect outcomes at the falling edge, where outputs are settled
    always @(negedge clk) begin
        seen_grant = seen_grant | level_grant;
        if (!chain_out_n) seen_pass = 1'b1;
        if (ack_data_oe) seen_vec = ack_data;
    end

    // Granted request consumed just after the edge, like all other stimulus
    always @(posedge clk) begin
        #1;
        if (!hold_req && level_grant[1]) tx_int_req = 1'b0;
        if (level_grant[2]) modem_int_req = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hw_ack(input int sel);
        int i;
        seen_grant = 0;
        seen_pass = 0;
        seen_vec = 0;
        host_addr = match_tab[sel];
        start = 1;
        tick(1);
        start = 0;
        for (i = 0; i < 40 && done !== 1'b1; i++) tick(1);
        chk("ack done", 1, done);
    endtask

    task automatic sw_ack(input int lvl);
        seen_grant = 0;
        seen_vec = 0;
        sw_ack_rd[lvl] = 1;
        tick(1);
        sw_ack_rd = 0;
        tick(3);
    endtask

    task automatic pulse_eos;
        eos_stb = 1;
        tick(1);
        eos_stb = 0;
        tick(8);
    endtask

    // Kind bits: err, special, break, timeout
    task automatic rx_in(input logic [3:0] kind);
        {nndt, brk, spec, err} = kind;
        stb = !kind[3];
        tick(1);
        {nndt, brk, spec, err, stb} = 0;
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Generous bound over the whole sequence
    initial begin
        #2000000;
        failures++;
        conclude();
    end

    initial begin
        tick(6);
        rst_n = 1;
        tick(4);
        chk("out quiet", 8'h01, {req_out, ack_data_oe, level_grant, chain_out_n});
        // Hardware acknowledge table
        foreach (rows[r]) begin
            tx_int_req = rows[r].txr;
            modem_int_req = rows[r].mdr;
            tick(6);
            hw_ack(rows[r].sel);
            chk("grant", rows[r].grant, seen_grant);
            chk("pass", rows[r].pass, seen_pass);
            if (rows[r].grant != 0) begin
                chk("vector", {GVR, rows[r].vtype}, seen_vec);
                chk("in service", rows[r].grant, in_service);
                pulse_eos();
            end
        end
        // Shared line held by a peer withholds our request
        hold_req = 1;
        peer_pull = 3'h2;
        tx_int_req = 1;
        tick(6);
        hw_ack(1);
        chk("fair grant", 2, seen_grant);
        pulse_eos();
        chk("tx withheld", 0, tx_oe);
        peer_pull = 0;
        tick(8);
        chk("tx reasserted", 1, tx_oe);
        hold_req = 0;
        sw_ack(1);
        chk("sw grant", 2, seen_grant);
        pulse_eos();
        // Receive order: clean, exception, late clean
        rx_in(0);
        rx_in(1);
        rx_in(0);
        tick(8);
        chk("rx count", 1, rx_clean_count);
        chk("rx req", 1, rx_oe);
        chk("exc pending", 1, rx_exc_pending);
        sw_ack(0);
        chk("clean vector", {GVR, `SRAC_VEC_RX_CLEAN}, seen_vec);
        rd_stb = 1;
        tick(1);
        rd_stb = 0;
        pulse_eos();
        sw_ack(0);
        chk("exc vector", {GVR, `SRAC_VEC_RX_EXC}, seen_vec);
        pulse_eos();
        chk("late clean", 1, rx_clean_count);
        chk("below threshold", 0, rx_oe);
        timer = 1;
        tick(1);
        timer = 0;
        tick(8);
        chk("timer req", 1, rx_oe);
        sw_ack(0);
        rx_in(0);
        rx_in(0);
        tick(2);
        chk("count in service", 3, rx_clean_count);
        pulse_eos();
        chk("re-request", 1, rx_oe);
        sw_ack(0);
        rd_stb = 1;
        tick(3);
        rd_stb = 0;
        pulse_eos();
        chk("drained", 8'h00, {rx_oe, rx_clean_count});
        // Special, break and timeout each report as exceptions
        foreach (match_tab[k]) begin
            if (k < 3) begin
                rx_in(4'h2 << k);
                tick(8);
                sw_ack(0);
                chk("exc kind", {GVR, `SRAC_VEC_RX_EXC}, seen_vec);
                pulse_eos();
            end
        end
        // A second exception while one is queued is dropped and flagged
        rx_in(1);
        rx_in(1);
        chk("overrun", 1, rx_overrun);
        tick(8);
        sw_ack(0);
        chk("exc kept", {GVR, `SRAC_VEC_RX_EXC}, seen_vec);
        pulse_eos();
        chk("exc cleared", 0, rx_exc_pending);
        // Reset in mid-run drops a standing request, which returns after release
        tx_int_req = 1;
        tick(4);
        rst_n = 0;
        tick(2);
        chk("reset quiet", 8'h01, {tx_oe, in_service, level_grant, chain_out_n});
        rst_n = 1;
        tick(3);
        chk("req after reset", 1, tx_oe);
        conclude();
    end
endmodule
